// File: design/gdi_gate_drive.sv
// Dual-channel gate-drive interlock with lockouts, dead time, boost and register port
//
// Function
// R01 - Channel supply bad forces that output low
// R02 - Channel lockout has upper/lower threshold hysteresis
// R03 - Outputs low until input supply first good
// R04 - Input supply loss forces outputs low
// R05 - Input lockout uses turn-on/turn-off hysteresis
// R06 - Single high command drives only its output
// R07 - Rising output waits for dead time expiry
// R08 - Both commands high with dead time: low
// R09 - Overlap mode: each output follows command
// R10 - Shutdown high forces both outputs low
// R11 - Open commands keep both outputs low
// R12 - Open inputs read as logic low
// R13 - Short input pulses are ignored
// R14 - Each output driven from its own command
// R15 - Boost pulse on each rising output
// R16 - Reject about 5 ns, pass 10 ns
// R17 - Falling command starts other channel's dead time
// R18 - Both high drops outputs at once
// R19 - Dead time is loaded down-counter
// R20 - Asynchronous inputs pass two flip-flops
// R21 - Reset clears outputs, boosts and counters
`timescale 1ns/1ps
module gdi_gate_drive (
	// Clock, reset, enable
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 ce_i,
	// Wishbone register port
	input  wire gdi_pkg::gdi_wb_req_s wb_req_i,
	output gdi_pkg::gdi_wb_rsp_s      wb_rsp_o,
	// Command pins from the PWM controller
	input  wire gdi_pkg::gdi_pins_s   pins_i,
	// Supply monitors
	input  wire gdi_pkg::gdi_supply_s input_side_supply_good_i,
	input  wire gdi_pkg::gdi_supply_s chan_a_supply_good_i,
	input  wire gdi_pkg::gdi_supply_s chan_b_supply_good_i,
	// Gate drive and boost enables
	output logic                      chan_a_drive_o,
	output logic                      chan_b_drive_o,
	output logic                      boost_a_o,
	output logic                      boost_b_o
);
	import gdi_pkg::*;

	// Synchronised raw inputs
	localparam int RAW_W = 9;
	logic [RAW_W-1:0]  raw_async;      // Pins and monitors as they arrive
	logic [RAW_W-1:0]  raw_sync;       // Same after two stages
	gdi_pins_s         pins_s;         // Synchronised pins, unfiltered
	gdi_supply_s       in_sup_s;       // Synchronised input-side monitor
	gdi_supply_s       ch_sup_s [2];   // Synchronised channel monitors

	// Filtered commands, index 0 is channel A and 1 is channel B
	logic [2:0]        flt;            // Filter outputs: A, B, shutdown
	logic [1:0]        cmd;            // Filtered channel commands
	logic              shutdown;       // Filtered shutdown request
	logic [1:0]        cmd_prev_r;     // Commands one cycle ago
	logic [1:0]        cmd_fall;       // Falling command this cycle

	// Lockouts
	gdi_uvlo_e         uv_state_r;     // Input-side lockout state
	gdi_uvlo_e         uv_state_nxt;   // Its next value
	logic              run_ok;         // Input side released
	logic              started_r;      // Input side has been good at least once
	logic [1:0]        chan_ok_r;      // Channel supplies released

	// Configuration registers
	logic [DT_W-1:0]   dt_set_r;       // Dead-time setting in cycles
	logic              overlap_r;      // Overlap mode, dead time off
	logic              dt_active;      // Interlock in force

	// Per-channel datapath
	logic [DT_W-1:0]   dt_cnt_r [2];   // Dead-time down-counters
	logic [1:0]        want_hi;        // Interlock verdict per channel
	logic [1:0]        drive_nxt;      // Next drive level
	logic [1:0]        drive_r;        // Registered drive level
	logic [BOOST_W-1:0] boost_cnt_r [2]; // Remaining boost cycles
	logic [1:0]        boost_r;        // Registered boost enables

	// Bus
	logic              wb_take;        // A new bus request is taken now and answered next cycle
	logic [31:0]       status;         // Assembled status word
	logic [31:0]       rd_word;        // Read data for the request

	// Input gathering
	// R20 two-stage sync
	assign raw_async = {pins_i, input_side_supply_good_i, chan_b_supply_good_i, chan_a_supply_good_i};

	gdi_sync #(
		.W(RAW_W)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.async_i (raw_async),
		.sync_o  (raw_sync)
	);

	// Split the synchronised vector back into its parts
	assign pins_s      = raw_sync[8:6];
	assign in_sup_s    = raw_sync[5:4];
	assign ch_sup_s[1] = raw_sync[3:2];
	assign ch_sup_s[0] = raw_sync[1:0];

	// Pulse filters on the three command pins
	// R13 R16 short pulses dropped
	generate
		for (genvar f = 0; f < 3; f++) begin : g_flt
			gdi_deglitch u_flt (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.ce_i  (ce_i),
				.lvl_i (pins_s[f]),
				.lvl_o (flt[f])
			);
		end
	endgenerate

	// R12 open reads low
	// An unconnected pin sits on its pad pull-down; every stage resets low, so low is idle
	assign cmd      = flt[1:0];
	assign shutdown = flt[2];

	// Previous command levels for edge detection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_prev_r <= 2'h0;
		end else if (ce_i) begin
			cmd_prev_r <= cmd;
		end
	end

	assign cmd_fall = cmd_prev_r & ~cmd;

	// Input-side lockout next state
	// R03 R05 hysteresis lockout
	always_comb begin
		uv_state_nxt = uv_state_r;
		case (uv_state_r)
			// Nothing passes until the upper threshold is first crossed
			UV_STARTUP: begin
				if (in_sup_s.above_on) begin
					uv_state_nxt = UV_RUN;
				end
			end
			// R04 drop below lower
			UV_RUN: begin
				if (!in_sup_s.above_off) begin
					uv_state_nxt = UV_LOCKED;
				end
			end
			// Re-release needs the upper threshold again, not just the lower
			UV_LOCKED: begin
				if (in_sup_s.above_on) begin
					uv_state_nxt = UV_RUN;
				end
			end
			default: begin
				uv_state_nxt = UV_STARTUP;
			end
		endcase
	end

	// Input-side lockout state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			uv_state_r <= UV_STARTUP;
		end else if (ce_i) begin
			uv_state_r <= uv_state_nxt;
		end
	end

	// Sticky start-up flag for status
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			started_r <= 1'b0;
		end else if (ce_i && uv_state_r == UV_RUN) begin
			started_r <= 1'b1;
		end
	end

	assign run_ok = (uv_state_r == UV_RUN);

	// Channel-side lockouts, each channel on its own
	// R02 channel hysteresis
	generate
		for (genvar c = 0; c < 2; c++) begin : g_lock
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					chan_ok_r[c] <= 1'b0;
				end else if (ce_i) begin
					// Lower threshold wins: a falling supply locks out at once
					if (!ch_sup_s[c].above_off) begin
						chan_ok_r[c] <= 1'b0;
					end else if (ch_sup_s[c].above_on) begin
						chan_ok_r[c] <= 1'b1;
					end
				end
			end
		end
	endgenerate

	// Interlock is bypassed in overlap mode or with a zero setting
	// R19 zero or overlap bypasses
	assign dt_active = !overlap_r && (dt_set_r != DT_SET_RST);

	// Per-channel dead time, gating and boost
	generate
		for (genvar i = 0; i < 2; i++) begin : g_chan
			localparam int O = 1 - i;   // Index of the opposite channel

			// Dead-time counter for this channel
			// R17 R19 load on other fall
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					dt_cnt_r[i] <= '0;
				end else if (ce_i) begin
					if (!dt_active) begin
						dt_cnt_r[i] <= '0;
					end else if (cmd_fall[O]) begin
						dt_cnt_r[i] <= dt_set_r;
					end else if (dt_cnt_r[i] != '0) begin
						dt_cnt_r[i] <= dt_cnt_r[i] - 1'b1;
					end
				end
			end

			// Interlock verdict, before lockout and shutdown gating
			always_comb begin
				if (dt_active) begin
					// R07 R08 R18 dead-time interlock
					// Both high drops at once; a rise also waits for the count and the other output
					want_hi[i] = cmd[i] && !cmd[O] && !cmd_fall[O] && (dt_cnt_r[i] == '0) && !drive_r[O];
				end else begin
					// R09 overlap follows command
					want_hi[i] = cmd[i];
				end
			end

			// R01 R04 R10 final gating
			// R06 R11 R14 own command only
			assign drive_nxt[i] = run_ok && chan_ok_r[i] && !shutdown && want_hi[i];

			// Drive register
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					drive_r[i] <= 1'b0;
				end else if (ce_i) begin
					drive_r[i] <= drive_nxt[i];
				end
			end

			// Boost enable, aligned with the rising output
			// R15 boost on rise
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					boost_cnt_r[i] <= '0;
					boost_r[i]     <= 1'b0;
				end else if (ce_i) begin
					if (!drive_nxt[i]) begin
						// A falling output cuts the boost short
						boost_cnt_r[i] <= '0;
						boost_r[i]     <= 1'b0;
					end else if (!drive_r[i]) begin
						boost_cnt_r[i] <= BOOST_W'(BOOST_CYC - 1);
						boost_r[i]     <= 1'b1;
					end else if (boost_cnt_r[i] != '0) begin
						boost_cnt_r[i] <= boost_cnt_r[i] - 1'b1;
					end else begin
						// Steady high: pull-up boost stays off
						boost_r[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Outputs straight from the registers
	// R21 reset holds low
	assign chan_a_drive_o = drive_r[0];
	assign chan_b_drive_o = drive_r[1];
	assign boost_a_o      = boost_r[0];
	assign boost_b_o      = boost_r[1];

	// Bus answer in the cycle after the request is seen, once per request
	assign wb_take = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;

	// Configuration register writes, byte lanes honoured
	// A write lands at the edge where the master sees ack, so a request dropped early never writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dt_set_r  <= DT_SET_RST;
			overlap_r <= OVERLAP_RST;
		end else if (ce_i) begin
			if (wb_req_i.cyc && wb_req_i.stb && wb_rsp_o.ack && wb_req_i.we &&
				gdi_hit(wb_req_i.adr, REG_DT_CFG_OFS)) begin
				if (wb_req_i.sel[0]) begin
					dt_set_r[7:0] <= wb_req_i.dat[DT_SET_LSB +: 8];
				end
				if (wb_req_i.sel[1]) begin
					dt_set_r[15:8] <= wb_req_i.dat[DT_SET_LSB + 8 +: 8];
				end
				if (wb_req_i.sel[2]) begin
					overlap_r <= wb_req_i.dat[OVERLAP_BIT];
				end
			end
		end
	end

	// Status word from live block state
	always_comb begin
		status               = 32'h0000_0000;
		status[STS_IN_OK]    = run_ok;
		status[STS_A_OK]     = chan_ok_r[0];
		status[STS_B_OK]     = chan_ok_r[1];
		status[STS_SHUTDOWN] = shutdown;
		status[STS_CMD_A]    = cmd[0];
		status[STS_CMD_B]    = cmd[1];
		status[STS_DRIVE_A]  = drive_r[0];
		status[STS_DRIVE_B]  = drive_r[1];
		status[STS_DT_A]     = (dt_cnt_r[0] != '0);
		status[STS_DT_B]     = (dt_cnt_r[1] != '0);
		status[STS_STARTED]  = started_r;
	end

	// Read mux; unmapped addresses read zero and still get an answer
	always_comb begin
		rd_word = 32'h0000_0000;
		if (gdi_hit(wb_req_i.adr, REG_DT_CFG_OFS)) begin
			rd_word[DT_SET_LSB +: DT_W] = dt_set_r;
			rd_word[OVERLAP_BIT]        = overlap_r;
		end else if (gdi_hit(wb_req_i.adr, REG_STATUS_OFS)) begin
			rd_word = status;
		end
	end

	// Acknowledge and read data registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_rsp_o <= '0;
		end else if (ce_i) begin
			wb_rsp_o.ack <= wb_take;
			if (wb_take && !wb_req_i.we) begin
				wb_rsp_o.dat <= rd_word;
			end
		end
	end
endmodule

// File: pkg/gdi_pkg.sv
// Shared constants, types and decode helpers of the dual gate-drive interlock
package gdi_pkg;

	// Clock rate in MHz (period 5 ns)
	localparam int CLK_MHZ = 200;

	// Deglitch: pulses up to this width are dropped (longest time, rounded down)
	localparam int T_REJECT_NS = 5;
	// Deglitch: pulses of this width always pass (least time, rounded up)
	localparam int T_PASS_NS   = 10;
	// Width of the boost-enable pulse on a rising output
	localparam int T_BOOST_NS  = 10;

	// Cycle counts derived from the times above, never below one cycle
	localparam int REJECT_CYC_RAW = (T_REJECT_NS * CLK_MHZ) / 1000;
	localparam int REJECT_CYC     = (REJECT_CYC_RAW < 1) ? 1 : REJECT_CYC_RAW;
	localparam int PASS_CYC_RAW   = (T_PASS_NS * CLK_MHZ + 999) / 1000;
	localparam int PASS_CYC       = (PASS_CYC_RAW <= REJECT_CYC) ? REJECT_CYC + 1 : PASS_CYC_RAW;
	localparam int BOOST_CYC_RAW  = (T_BOOST_NS * CLK_MHZ + 999) / 1000;
	localparam int BOOST_CYC      = (BOOST_CYC_RAW < 1) ? 1 : BOOST_CYC_RAW;

	// Counter widths
	localparam int FLT_W   = 4;
	localparam int BOOST_W = 4;
	localparam int DT_W    = 16;

	// Register map (byte addresses)
	localparam int          ADR_W          = 8;
	localparam logic [7:0]  REG_DT_CFG_OFS = 8'h00;
	localparam logic [7:0]  REG_STATUS_OFS = 8'h04;

	// Dead-time configuration register fields
	localparam int          DT_SET_LSB     = 0;
	localparam int          OVERLAP_BIT    = 16;
	localparam logic [15:0] DT_SET_RST     = 16'h0000;
	localparam logic        OVERLAP_RST    = 1'b1;

	// Status register bit positions
	localparam int STS_IN_OK    = 0;
	localparam int STS_A_OK     = 1;
	localparam int STS_B_OK     = 2;
	localparam int STS_SHUTDOWN = 3;
	localparam int STS_CMD_A    = 4;
	localparam int STS_CMD_B    = 5;
	localparam int STS_DRIVE_A  = 6;
	localparam int STS_DRIVE_B  = 7;
	localparam int STS_DT_A     = 8;
	localparam int STS_DT_B     = 9;
	localparam int STS_STARTED  = 10;

	// Input-side lockout states
	typedef enum logic [1:0] {
		UV_STARTUP,
		UV_RUN,
		UV_LOCKED
	} gdi_uvlo_e;

	// One supply monitor: above the upper and above the lower threshold
	typedef struct packed {
		logic above_on;
		logic above_off;
	} gdi_supply_s;

	// Command pins from the PWM controller
	typedef struct packed {
		logic shutdown_req;
		logic chan_b_cmd;
		logic chan_a_cmd;
	} gdi_pins_s;

	// Wishbone classic request
	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [3:0]        sel;
		logic [ADR_W-1:0]  adr;
		logic [31:0]       dat;
	} gdi_wb_req_s;

	// Wishbone classic response
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} gdi_wb_rsp_s;

	// Word-aligned address match
	function automatic logic gdi_hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
		gdi_hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
	endfunction

endpackage

// File: design/gdi_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module gdi_sync #(
	parameter int W = 1
) (
	// Clock, reset, enable
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	// Levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	import gdi_pkg::*;

	logic [W-1:0] meta_r;   // First stage, read only by the second

	// Both stages reset low, so an open input idles as low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_o <= '0;
		end else if (ce_i) begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end
endmodule

// File: design/gdi_deglitch.sv
// Pulse filter: output follows the input only after a stable run of samples
`timescale 1ns/1ps
module gdi_deglitch (
	// Clock, reset, enable
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Level in and filtered level out
	input  wire logic lvl_i,
	output logic      lvl_o
);
	import gdi_pkg::*;

	localparam logic [FLT_W-1:0] LAST = FLT_W'(PASS_CYC - 1);

	logic [FLT_W-1:0] run_r;   // Samples seen differing from the output

	// A differing run shorter than the pass time is dropped and the output holds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_r <= '0;
			lvl_o <= 1'b0;
		end else if (ce_i) begin
			if (lvl_i == lvl_o) begin
				run_r <= '0;
			end else if (run_r == LAST) begin
				run_r <= '0;
				lvl_o <= lvl_i;
			end else begin
				run_r <= run_r + 1'b1;
			end
		end
	end
endmodule

// File: verification/gdi_pwm_model.sv
// PWM controller model driving the command pins
`timescale 1ns/1ps
module gdi_pwm_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Wanted levels, open mask, own gap
	input  wire logic [2:0] want_i,
	input  wire logic [2:0] open_i,
	input  wire logic [7:0] gap_i,
	// Pins, released when left open
	output wire logic [2:0] pins_o
);
	logic [2:0] lvl_r; // Levels on the pins
	logic [7:0] gap_r; // Both-low cycles left
	// A swap with a gap first parks both channels low, acting as a slow controller
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_r <= 3'h0;
			gap_r <= 8'h00;
		end else if (gap_r != 8'h00) begin
			gap_r <= gap_r - 8'h01;
		end else if (gap_i != 8'h00 && (lvl_r[1:0] & ~want_i[1:0]) != 2'h0 && (want_i[1:0] & ~lvl_r[1:0]) != 2'h0) begin
			lvl_r <= {want_i[2], 2'h0};
			gap_r <= gap_i;
		end else begin
			lvl_r <= want_i;
		end
	end
	// Open pins float so the board pull-down decides
	for (genvar i = 0; i < 3; i++) begin : g_pin
		assign pins_o[i] = open_i[i] ? 1'bz : lvl_r[i];
	end
endmodule

// File: verification/gdi_gate_drive_chk.sv
// Checker of the gate-drive output rules, bound to the top module
`timescale 1ns/1ps
module gdi_gate_drive_chk (
	// Clock, reset, enable
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 ce_i,
	// Register port
	input wire gdi_pkg::gdi_wb_req_s wb_req_i,
	input wire gdi_pkg::gdi_wb_rsp_s wb_rsp_o,
	// Pins and supplies
	input wire gdi_pkg::gdi_pins_s   pins_i,
	input wire gdi_pkg::gdi_supply_s input_side_supply_good_i,
	input wire gdi_pkg::gdi_supply_s chan_a_supply_good_i,
	input wire gdi_pkg::gdi_supply_s chan_b_supply_good_i,
	// Drives and boosts
	input wire logic                 chan_a_drive_o,
	input wire logic                 chan_b_drive_o,
	input wire logic                 boost_a_o,
	input wire logic                 boost_b_o
);
	import gdi_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);
	a_boost_a_rise: assert property ($rose(chan_a_drive_o) |->
		boost_a_o ##1 (boost_a_o || !chan_a_drive_o) ##1 !boost_a_o) else $error("boost A pulse wrong");
	a_boost_b_rise: assert property ($rose(chan_b_drive_o) |->
		boost_b_o ##1 (boost_b_o || !chan_b_drive_o) ##1 !boost_b_o) else $error("boost B pulse wrong");
	a_boost_quiet: assert property (boost_a_o |-> chan_a_drive_o && !$past(chan_a_drive_o, 2))
		else $error("boost A outside rise");
	a_shut_low: assert property (pins_i.shutdown_req [*6] |-> !chan_a_drive_o && !chan_b_drive_o)
		else $error("drive high in shutdown");
	a_chan_uv_low: assert property (!chan_a_supply_good_i.above_off [*6] |-> !chan_a_drive_o)
		else $error("drive A high on low supply");
	a_in_uv_low: assert property (!input_side_supply_good_i.above_off [*6] |-> !chan_a_drive_o && !chan_b_drive_o)
		else $error("drive high on input lockout");
	a_drive_cause: assert property ($rose(chan_a_drive_o) |->
		$past(pins_i.chan_a_cmd, 4) && !$past(pins_i.shutdown_req, 4)) else $error("drive A rose uncommanded");
	a_wb_ack_next: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
		else $error("ack late");
	a_wb_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
		else $error("ack longer than one cycle");
endmodule
bind gdi_gate_drive gdi_gate_drive_chk u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pins_i(pins_i),
	.input_side_supply_good_i(input_side_supply_good_i), .chan_a_supply_good_i(chan_a_supply_good_i),
	.chan_b_supply_good_i(chan_b_supply_good_i), .chan_a_drive_o(chan_a_drive_o),
	.chan_b_drive_o(chan_b_drive_o), .boost_a_o(boost_a_o), .boost_b_o(boost_b_o));

// File: verification/gdi_gate_drive_tb_top.sv
// Self-checking bench of the dual gate-drive interlock
`timescale 1ns/1ps
module gdi_gate_drive_tb_top;
	import gdi_pkg::*;
	// Row: overlap, pins, open mask, expected drives {b,a}
	typedef struct packed {
		logic       ovl;
		logic [2:0] w;
		logic [2:0] o;
		logic [1:0] e;
	} gdi_row_s;
	logic        clk_i;        // 200 MHz clock
	logic        rst_i;        // Sync reset
	logic        ce;           // Clock enable
	gdi_wb_req_s req;          // Bus request
	gdi_wb_rsp_s rsp;          // Bus response
	gdi_supply_s sup_i;        // Input-side monitor
	gdi_supply_s sup_a;        // Channel A monitor
	gdi_supply_s sup_b;        // Channel B monitor
	logic [2:0]  want;         // Wanted pin levels
	logic [2:0]  opn;          // Pins left open
	logic [7:0]  gap;          // Controller gap
	tri0  [2:0]  pins_w;       // Pins with pull-downs
	logic        da;           // Drive A
	logic        db;           // Drive B
	logic        ba;           // Boost A
	logic        bb;           // Boost B
	logic [31:0] q;            // Read data
	logic        s;            // Seen high
	int          n;            // Cycle count
	int          error_cnt;    // Mismatches
	int          total_checks; // Comparisons
	logic [1:0]  sv [4] = '{2'h1, 2'h0, 2'h1, 2'h3}; // Supply steps {on,off}
	logic [3:0]  se = 4'h9;    // Drive expected per step
	gdi_row_s    rows [9] = '{{1'h1, 3'h0, 3'h0, 2'h0}, {1'h1, 3'h1, 3'h0, 2'h1}, {1'h1, 3'h2, 3'h0, 2'h2},
		{1'h1, 3'h3, 3'h0, 2'h3}, {1'h1, 3'h7, 3'h0, 2'h0}, {1'h1, 3'h3, 3'h3, 2'h0},
		{1'h1, 3'h5, 3'h4, 2'h1}, {1'h0, 3'h3, 3'h0, 2'h0}, {1'h0, 3'h0, 3'h0, 2'h0}};
	gdi_pwm_model u_pwm (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .open_i(opn), .gap_i(gap), .pins_o(pins_w));
	gdi_gate_drive u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req), .wb_rsp_o(rsp),
		.pins_i(gdi_pins_s'(pins_w)), .input_side_supply_good_i(sup_i), .chan_a_supply_good_i(sup_a),
		.chan_b_supply_good_i(sup_b), .chan_a_drive_o(da), .chan_b_drive_o(db), .boost_a_o(ba), .boost_b_o(bb));
	// Free-running clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// Counts then verdict; the only exit
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// Classic single cycle; holds until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
		do begin
			@(posedge clk_i);
			k++;
			if (k == 50) begin
				error_cnt++;
				end_sim();
			end
		end while (rsp.ack !== 1'b1);
		r = rsp.dat;
		req <= '0;
		@(posedge clk_i);
	endtask
	task automatic pin(input logic [2:0] w, input logic [2:0] o);
		want <= w;
		opn <= o;
	endtask
	// Bounded wait for pin B (p=1) or drive B (p=0)
	task automatic wfor(input logic p, output int k);
		k = 0;
		while ((p ? pins_w[1] : db) !== 1'b1) begin
			cyc(1);
			k++;
			if (k == 200) begin
				error_cnt++;
				end_sim();
			end
		end
	endtask
	initial begin
		rst_i = 1'h1;
		ce = 1'b1;
		req = '0;
		sup_i = '0;
		sup_a = '0;
		sup_b = '0;
		want = 3'h1;
		opn = 3'h0;
		gap = 8'h00;
		error_cnt = 0;
		total_checks = 0;
		cyc(4);
		rst_i <= 1'h0;
		// Supplies never good: command must be ignored
		cyc(20);
		chk("startup", 32'h0, {31'h0, da});
		wb(1'h0, 8'h00, 32'h0, q);
		chk("cfg reset", 32'h0001_0000, q);
		wb(1'h1, 8'h08, 32'hFFFF_FFFF, q);
		wb(1'h0, 8'h08, 32'h0, q);
		chk("unmapped", 32'h0, q);
		sup_i <= 2'h3;
		sup_a <= 2'h3;
		sup_b <= 2'h3;
		cyc(10);
		// Released, both channels good, only command A high and driven
		wb(1'h0, 8'h04, 32'h0, q);
		chk("status", 32'h0000_0457, q);
		foreach (rows[i]) begin
			wb(1'h1, 8'h00, {15'h0, rows[i].ovl, 16'h0014}, q);
			pin(rows[i].w, rows[i].o);
			cyc(10);
			chk("drive", {30'h0, rows[i].e}, {30'h0, db, da});
		end
		wb(1'h0, 8'h00, 32'h0, q);
		chk("cfg rw", 32'h0000_0014, q);
		// One-cycle pulse dropped, two-cycle pulse passed
		for (int l = 1; l < 3; l++) begin
			pin(3'h2, 3'h0);
			cyc(l);
			pin(3'h0, 3'h0);
			s = 1'b0;
			repeat (12) begin
				cyc(1);
				s |= db;
			end
			chk("glitch", l - 1, {31'h0, s});
		end
		// Prompt swap: B waits out the dead time of 20 cycles
		pin(3'h1, 3'h0);
		cyc(40);
		pin(3'h2, 3'h0);
		wfor(1'b0, n);
		chk("dt wait", 32'h1, {31'h0, n >= 21 && n <= 32});
		// Slow swap: gap longer than dead time, B follows at once
		pin(3'h1, 3'h0);
		gap <= 8'h28;
		// Long enough for A to rise after the controller's own gap
		cyc(60);
		pin(3'h2, 3'h0);
		wfor(1'b1, n);
		wfor(1'b0, n);
		chk("late cmd", 32'h1, {31'h0, n >= 2 && n <= 7});
		gap <= 8'h00;
		// Lockout steps for channel A, then the input side
		wb(1'h1, 8'h00, 32'h0001_0000, q);
		pin(3'h3, 3'h0);
		cyc(10);
		for (int k = 0; k < 2; k++) begin
			for (int j = 0; j < 4; j++) begin
				if (k == 0) begin
					sup_a <= gdi_supply_s'(sv[j]);
				end else begin
					sup_i <= gdi_supply_s'(sv[j]);
				end
				cyc(10);
				chk("uvlo", {30'h0, (k != 0) ? {se[j], se[j]} : {1'h1, se[j]}}, {30'h0, db, da});
			end
		end
		// Clock enable low freezes the drives while the commands drop
		ce <= 1'b0;
		pin(3'h0, 3'h0);
		cyc(10);
		chk("freeze", 32'h3, {30'h0, db, da});
		ce <= 1'b1;
		cyc(10);
		chk("thaw", 32'h0, {30'h0, db, da});
		// Boost stands for its set width on the rise, then stays off
		pin(3'h3, 3'h0);
		n = 0;
		repeat (12) begin
			cyc(1);
			if (ba === 1'b1) begin
				n++;
			end
		end
		chk("boost len", BOOST_CYC, n);
		// Reset in mid-run with both drives high
		rst_i <= 1'h1;
		cyc(2);
		chk("reset out", 32'h0, {28'h0, bb, ba, db, da});
		rst_i <= 1'h0;
		cyc(1);
		wb(1'h0, 8'h00, 32'h0, q);
		chk("cfg reset", 32'h0001_0000, q);
		cyc(10);
		end_sim();
	end
endmodule
